// >>> src/tol_trip.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - each of four outputs has an enable, default off; disabled never asserts
// - alarm 1 at theta over its threshold, 0.1 % steps, default 40 %
// - alarm 2 on its own threshold, same range, default 40 %
// - inhibit default 80 %, trip default 100 %, own thresholds
// - trip delayed by 0 to 3600 s in 5 ms steps, default none
// - alarms and inhibit direct; only trip passes block check
// - block input registered every clock; each tick uses the value taken the clock before
// - pickup with block inactive gives start and runs trip timing
// - pickup with block active gives blocked, no further trip processing
// - block rising during start clears start, timer released
// - each blocking raises display and time-stamped event with current and type; no time stamp is kept, only current and load code
// - in forcing mode a software switch drives the block input
// - condition code 0 normal..5 blocked; normal drives no output; start can still assert while the code is normal
// - load status code from current against 1 %, pickup, 2 x nominal
// - bad service factor flags fault and uses 1.0
// - bad ambient settings flag fault and use 1.0; a bad k limit pair is only flagged, k in use is kept
// - bad nominal current setting flags fault and uses 1.0
// - inconsistent ambient k flagged while it persists
module tol_trip #(
	parameter int unsigned P_CYCLE_CLKS = tol_pkg::CYCLE_CLKS
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic [7:0]  i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// process inputs
	input  wire logic [10:0] i_theta,
	input  wire logic [15:0] i_current,
	input  wire logic        i_block,
	// stage outputs
	output logic             o_alarm1,
	output logic             o_alarm2,
	output logic             o_inhibit,
	output logic             o_trip,
	output logic             o_start,
	output logic             o_blocked,
	output logic [2:0]       o_cond,
	output logic [1:0]       o_load,
	// blocking event
	output logic             o_blk_evt,
	output logic             o_hmi_evt,
	output logic [15:0]      o_evt_cur,
	output logic [1:0]       o_evt_type,
	// factors in use
	output logic [9:0]       o_sf_used,
	output logic [9:0]       o_k_used,
	output logic [9:0]       o_inom_used,
	output logic [3:0]       o_set_flt
);
	// settings
	logic [5:0]  ctrl_q;
	logic [10:0] lvl_a1_q;
	logic [10:0] lvl_a2_q;
	logic [10:0] lvl_inh_q;
	logic [10:0] lvl_trip_q;
	logic [19:0] dly_q;
	logic [15:0] pickup_q;
	logic [9:0]  sf_q;
	logic [9:0]  k_q;
	logic [9:0]  inom_q;
	logic [9:0]  kmax_q;
	logic [9:0]  kmin_q;

	// stage state
	logic        blk_q;
	logic        pready_q;

	wire         tick;
	wire         expired;

	tol_set_if set_if ();

	// ---------------- apb decode ----------------
	wire setup  = i_psel & ~i_penable;
	wire wr_acc = i_psel & i_penable & i_pwrite & o_pready;

	wire s_ctrl  = i_paddr == tol_pkg::A_CTRL;
	wire s_a1    = i_paddr == tol_pkg::A_LVL_A1;
	wire s_a2    = i_paddr == tol_pkg::A_LVL_A2;
	wire s_inh   = i_paddr == tol_pkg::A_LVL_INH;
	wire s_trip  = i_paddr == tol_pkg::A_LVL_TRIP;
	wire s_dly   = i_paddr == tol_pkg::A_TRIP_DLY;
	wire s_pick  = i_paddr == tol_pkg::A_PICKUP;
	wire s_sf    = i_paddr == tol_pkg::A_SVC_FAC;
	wire s_k     = i_paddr == tol_pkg::A_AMB_K;
	wire s_inom  = i_paddr == tol_pkg::A_INOM;
	wire s_klim  = i_paddr == tol_pkg::A_KLIM;
	wire s_stat  = i_paddr == tol_pkg::A_STATUS;
	wire s_used  = i_paddr == tol_pkg::A_USED;

	wire mapped = s_ctrl | s_a1 | s_a2 | s_inh | s_trip | s_dly
		| s_pick | s_sf | s_k | s_inom | s_klim | s_stat | s_used;

	wire [31:0] status_w = {16'h0000, o_set_flt,
		o_trip, o_inhibit, o_alarm2, o_alarm1,
		o_blocked, o_start, o_load, 1'b0, o_cond};

	wire [31:0] used_w = {2'b00, o_inom_used, o_k_used, o_sf_used};

	wire [31:0] rd_data =
		s_ctrl ? {26'h0000000, ctrl_q} :
		s_a1   ? {21'h000000, lvl_a1_q} :
		s_a2   ? {21'h000000, lvl_a2_q} :
		s_inh  ? {21'h000000, lvl_inh_q} :
		s_trip ? {21'h000000, lvl_trip_q} :
		s_dly  ? {12'h000, dly_q} :
		s_pick ? {16'h0000, pickup_q} :
		s_sf   ? {22'h000000, sf_q} :
		s_k    ? {22'h000000, k_q} :
		s_inom ? {22'h000000, inom_q} :
		s_klim ? {6'h00, kmin_q, 6'h00, kmax_q} :
		s_stat ? status_w :
		s_used ? used_w :
		32'h00000000;

	// one wait-free access phase; answer prepared in setup
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pready_q  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end else begin
			pready_q  <= setup;
			o_pslverr <= setup & ~mapped;
			o_prdata  <= setup ? rd_data : 32'h00000000;
		end
	end

	assign o_pready = pready_q;

	// ---------------- register writes ----------------
	// enables default off
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= tol_pkg::RST_CTRL;
		end else if (wr_acc && s_ctrl) begin
			ctrl_q <= i_pwdata[5:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			lvl_a1_q   <= tol_pkg::RST_LVL_A1;
			lvl_a2_q   <= tol_pkg::RST_LVL_A2;
			lvl_inh_q  <= tol_pkg::RST_LVL_INH;
			lvl_trip_q <= tol_pkg::RST_LVL_TRIP;
		end else if (wr_acc) begin
			if (s_a1) begin
				lvl_a1_q <= i_pwdata[10:0];
			end
			if (s_a2) begin
				lvl_a2_q <= i_pwdata[10:0];
			end
			if (s_inh) begin
				lvl_inh_q <= i_pwdata[10:0];
			end
			if (s_trip) begin
				lvl_trip_q <= i_pwdata[10:0];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			dly_q <= tol_pkg::RST_DLY;
		end else if (wr_acc && s_dly) begin
			dly_q <= (i_pwdata[19:0] > tol_pkg::DLY_MAX) ? tol_pkg::DLY_MAX : i_pwdata[19:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pickup_q <= tol_pkg::RST_PICKUP;
			sf_q     <= tol_pkg::K_ONE;
			k_q      <= tol_pkg::K_ONE;
			inom_q   <= tol_pkg::K_ONE;
			kmax_q   <= tol_pkg::K_ONE;
			kmin_q   <= tol_pkg::K_ONE;
		end else if (wr_acc) begin
			if (s_pick) begin
				pickup_q <= i_pwdata[15:0];
			end
			if (s_sf) begin
				sf_q <= i_pwdata[9:0];
			end
			if (s_k) begin
				k_q <= i_pwdata[9:0];
			end
			if (s_inom) begin
				inom_q <= i_pwdata[9:0];
			end
			if (s_klim) begin
				kmax_q <= i_pwdata[9:0];
				kmin_q <= i_pwdata[tol_pkg::KLIM_MIN_LSB +: 10];
			end
		end
	end

	// ---------------- setting checks ----------------
	assign set_if.sf_set   = sf_q;
	assign set_if.k_set    = k_q;
	assign set_if.inom_set = inom_q;
	assign set_if.kmax_set = kmax_q;
	assign set_if.kmin_set = kmin_q;

	tol_setchk u_setchk (
		.s (set_if.chk)
	);

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_sf_used   <= tol_pkg::K_ONE;
			o_k_used    <= tol_pkg::K_ONE;
			o_inom_used <= tol_pkg::K_ONE;
			o_set_flt   <= 4'h0;
		end else begin
			o_sf_used   <= set_if.sf_used;
			o_k_used    <= set_if.k_used;
			o_inom_used <= set_if.inom_used;
			o_set_flt   <= set_if.flt;
		end
	end

	// ---------------- stage decision ----------------
	wire [3:0] en = ctrl_q[tol_pkg::CTRL_EN_LSB +: 4];

	wire blk_src = ctrl_q[tol_pkg::CTRL_FORCE_BIT] ?
		ctrl_q[tol_pkg::CTRL_SWBLK_BIT] : i_block;

	wire reach_a1   = i_theta >= lvl_a1_q;
	wire reach_a2   = i_theta >= lvl_a2_q;
	wire reach_inh  = i_theta >= lvl_inh_q;
	wire reach_trip = i_theta >= lvl_trip_q;

	wire a1_d  = en[0] & reach_a1;
	wire a2_d  = en[1] & reach_a2;
	wire inh_d = en[2] & reach_inh;
	wire pick  = en[3] & reach_trip;

	wire start_d = pick & ~blk_q;
	wire blocked_d = pick & blk_q;
	wire trip_d = start_d & expired;

	wire [2:0] cond_d =
		blocked_d ? tol_pkg::COND_BLOCKED :
		trip_d    ? tol_pkg::COND_TRIP :
		inh_d     ? tol_pkg::COND_INHIBIT :
		a2_d      ? tol_pkg::COND_ALARM2 :
		a1_d      ? tol_pkg::COND_ALARM1 :
		tol_pkg::COND_NORMAL;

	wire [1:0] load_d =
		(i_current < tol_pkg::CUR_1PCT) ? tol_pkg::LOAD_LIGHT :
		(i_current > tol_pkg::CUR_2IN)  ? tol_pkg::LOAD_HIGH :
		(i_current > pickup_q)          ? tol_pkg::LOAD_OVER :
		tol_pkg::LOAD_NORMAL;

	tol_timer #(
		.P_CYCLE_CLKS (P_CYCLE_CLKS)
	) u_timer (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_run      (start_d),
		.i_delay    (dly_q),
		.o_tick     (tick),
		.o_expired  (expired)
	);

	// block registered on every clock edge
	// the value held at the tick edge is the one taken the edge before,
	// so block is fixed ahead of every threshold and timer decision
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			blk_q <= 1'b0;
		end else begin
			blk_q <= blk_src;
		end
	end

	// outputs refresh once per processing cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_alarm1  <= 1'b0;
			o_alarm2  <= 1'b0;
			o_inhibit <= 1'b0;
			o_trip    <= 1'b0;
			o_start   <= 1'b0;
			o_blocked <= 1'b0;
			o_cond    <= tol_pkg::COND_NORMAL;
		end else if (tick) begin
			o_alarm1  <= a1_d;
			o_alarm2  <= a2_d;
			o_inhibit <= inh_d;
			o_trip    <= trip_d;
			o_start   <= start_d;
			o_blocked <= blocked_d;
			o_cond    <= cond_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_load <= tol_pkg::LOAD_LIGHT;
		end else begin
			o_load <= load_d;
		end
	end

	wire blk_rise = tick & blocked_d & ~o_blocked;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_blk_evt <= 1'b0;
			o_hmi_evt <= 1'b0;
		end else begin
			o_blk_evt <= blk_rise;
			o_hmi_evt <= blk_rise;
		end
	end

	// payload holds until the next blocking
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_evt_cur  <= 16'h0000;
			o_evt_type <= tol_pkg::LOAD_LIGHT;
		end else if (blk_rise) begin
			o_evt_cur  <= i_current;
			o_evt_type <= load_d;
		end
	end

	// block lead time
	// a block taken before one tick acts on that tick's trip decision,
	// so the source must be stable one clock ahead of expiry
endmodule // tol_trip
`default_nettype wire

// >>> src/tol_pkg.sv
`default_nettype none
package tol_pkg;
	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CYCLE_TIME_MS = 5;
	localparam int unsigned CYCLE_CLKS    = (CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	// widths
	localparam int unsigned LVL_W = 11;
	localparam int unsigned DLY_W = 20;
	localparam int unsigned K_W   = 10;
	localparam int unsigned CUR_W = 16;
	// register byte offsets
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_LVL_A1   = 8'h04;
	localparam logic [7:0] A_LVL_A2   = 8'h08;
	localparam logic [7:0] A_LVL_INH  = 8'h0c;
	localparam logic [7:0] A_LVL_TRIP = 8'h10;
	localparam logic [7:0] A_TRIP_DLY = 8'h14;
	localparam logic [7:0] A_PICKUP   = 8'h18;
	localparam logic [7:0] A_SVC_FAC  = 8'h1c;
	localparam logic [7:0] A_AMB_K    = 8'h20;
	localparam logic [7:0] A_INOM     = 8'h24;
	localparam logic [7:0] A_KLIM     = 8'h28;
	localparam logic [7:0] A_STATUS   = 8'h2c;
	localparam logic [7:0] A_USED     = 8'h30;
	// control fields
	localparam int unsigned CTRL_EN_LSB    = 0;
	localparam int unsigned CTRL_FORCE_BIT = 4;
	localparam int unsigned CTRL_SWBLK_BIT = 5;
	localparam int unsigned KLIM_MIN_LSB   = 16;
	// reset values, thresholds in 0.1 %
	localparam logic [5:0]       RST_CTRL     = 6'h00;
	localparam logic [LVL_W-1:0] RST_LVL_A1   = 11'h190;
	localparam logic [LVL_W-1:0] RST_LVL_A2   = 11'h190;
	localparam logic [LVL_W-1:0] RST_LVL_INH  = 11'h320;
	localparam logic [LVL_W-1:0] RST_LVL_TRIP = 11'h3e8;
	localparam logic [DLY_W-1:0] RST_DLY      = 20'h00000;
	localparam logic [DLY_W-1:0] DLY_MAX      = 20'hafc80;
	// factors in hundredths
	localparam logic [K_W-1:0] K_ONE  = 10'h064;
	localparam logic [K_W-1:0] K_LO   = 10'h001;
	localparam logic [K_W-1:0] K_HI   = 10'h1f4;
	localparam logic [K_W-1:0] SF_LO  = 10'h064;
	localparam logic [K_W-1:0] SF_HI  = 10'h0c8;
	// currents in 0.01 x nominal
	localparam logic [CUR_W-1:0] CUR_1PCT   = 16'h0001;
	localparam logic [CUR_W-1:0] CUR_2IN    = 16'h00c8;
	localparam logic [CUR_W-1:0] RST_PICKUP = 16'h0064;

	typedef enum logic [2:0] {
		COND_NORMAL  = 3'b000,
		COND_ALARM1  = 3'b001,
		COND_ALARM2  = 3'b010,
		COND_INHIBIT = 3'b011,
		COND_TRIP    = 3'b100,
		COND_BLOCKED = 3'b101
	} tol_cond_e;

	typedef enum logic [1:0] {
		LOAD_LIGHT  = 2'b00,
		LOAD_HIGH   = 2'b01,
		LOAD_OVER   = 2'b10,
		LOAD_NORMAL = 2'b11
	} tol_load_e;
endpackage
`default_nettype wire

// >>> src/tol_set_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tol_set_if;
	logic [9:0] sf_set;
	logic [9:0] k_set;
	logic [9:0] inom_set;
	logic [9:0] kmax_set;
	logic [9:0] kmin_set;
	logic [9:0] sf_used;
	logic [9:0] k_used;
	logic [9:0] inom_used;
	logic [3:0] flt;
	modport top (output sf_set, k_set, inom_set, kmax_set, kmin_set,
		input sf_used, k_used, inom_used, flt);
	modport chk (input sf_set, k_set, inom_set, kmax_set, kmin_set,
		output sf_used, k_used, inom_used, flt);
endinterface
`default_nettype wire

// >>> src/tol_setchk.sv
`timescale 1ns/1ps
`default_nettype none
module tol_setchk (
	tol_set_if.chk s
);
	wire sf_bad   = (s.sf_set < tol_pkg::SF_LO) | (s.sf_set > tol_pkg::SF_HI);
	wire k_bad    = (s.k_set < tol_pkg::K_LO) | (s.k_set > tol_pkg::K_HI);
	wire inom_bad = (s.inom_set < tol_pkg::K_LO) | (s.inom_set > tol_pkg::K_HI);
	// k at hot end above k at cold end cannot be right
	wire klim_bad = s.kmax_set > s.kmin_set;

	assign s.sf_used   = sf_bad ? tol_pkg::K_ONE : s.sf_set;
	assign s.k_used    = k_bad ? tol_pkg::K_ONE : s.k_set;
	assign s.inom_used = inom_bad ? tol_pkg::K_ONE : s.inom_set;
	assign s.flt       = {klim_bad, inom_bad, k_bad, sf_bad};
endmodule // tol_setchk
`default_nettype wire

// >>> src/tol_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tol_timer #(
	parameter int unsigned P_CYCLE_CLKS = tol_pkg::CYCLE_CLKS
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// control
	input  wire logic        i_run,
	input  wire logic [19:0] i_delay,
	// status
	output logic             o_tick,
	output logic             o_expired
);
	localparam int unsigned TW = $clog2(P_CYCLE_CLKS + 1);
	localparam logic [TW-1:0] LAST = TW'(P_CYCLE_CLKS - 1);

	logic [TW-1:0] div_q;
	logic [19:0]   cnt_q;
	wire           wrap = div_q == LAST;

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || wrap) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + TW'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= wrap;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cnt_q <= 20'h00000;
		end else if (o_tick) begin
			if (!i_run) begin
				cnt_q <= 20'h00000;
			end else if (cnt_q != 20'hfffff) begin
				cnt_q <= cnt_q + 20'h00001;
			end
		end
	end

	assign o_expired = cnt_q >= i_delay;
endmodule // tol_timer
`default_nettype wire

// >>> tb/tol_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tol_checker #(
	parameter int unsigned P_CYCLE_CLKS = tol_pkg::CYCLE_CLKS
) (
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	// watched ports
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        o_pready,
	input wire logic [15:0] i_current,
	input wire logic        i_block,
	input wire logic        o_alarm1,
	input wire logic        o_alarm2,
	input wire logic        o_inhibit,
	input wire logic        o_trip,
	input wire logic        o_start,
	input wire logic        o_blocked,
	input wire logic [2:0]  o_cond,
	input wire logic [1:0]  o_load,
	input wire logic        o_blk_evt,
	input wire logic        o_hmi_evt,
	input wire logic [9:0]  o_sf_used,
	input wire logic [9:0]  o_k_used,
	input wire logic [9:0]  o_inom_used,
	input wire logic [3:0]  o_set_flt
);
	// one tick plus the output register and margin
	localparam int LIM = P_CYCLE_CLKS + 4;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence blk_rise;
		$rose(o_blocked);
	endsequence
	sequence evt_once;
		o_hmi_evt ##1 !o_blk_evt;
	endsequence
	trip_code_a: assert property (o_trip |-> !o_blocked && o_cond == tol_pkg::COND_TRIP)
		else $error("trip with block or wrong code");
	start_excl_a: assert property (o_blocked |-> !o_start && o_cond == tol_pkg::COND_BLOCKED)
		else $error("blocked with start or wrong code");
	evt_pulse_a: assert property (o_blk_evt |-> evt_once)
		else $error("event not a single pulse");
	evt_on_block_a: assert property (blk_rise |-> ##[0:1] o_blk_evt)
		else $error("no event on blocking");
	normal_quiet_a: assert property (o_cond == tol_pkg::COND_NORMAL |-> !(o_alarm1 | o_alarm2 | o_inhibit | o_trip))
		else $error("output driven in normal state");
	block_clears_a: assert property (o_start && i_block |-> ##[1:LIM] (!o_start || !i_block))
		else $error("start kept under block");
	load_light_a: assert property ($past(i_rst_n) && i_current < tol_pkg::CUR_1PCT |=> o_load == tol_pkg::LOAD_LIGHT)
		else $error("light load code wrong");
	load_high_a: assert property ($past(i_rst_n) && i_current > tol_pkg::CUR_2IN |=> o_load == tol_pkg::LOAD_HIGH)
		else $error("high overload code wrong");
	sf_force_a: assert property (o_set_flt[0] |-> o_sf_used == tol_pkg::K_ONE)
		else $error("service factor not forced");
	amb_force_a: assert property (o_set_flt[1] |-> o_k_used == tol_pkg::K_ONE)
		else $error("ambient factor not forced");
	nom_force_a: assert property (o_set_flt[2] |-> o_inom_used == tol_pkg::K_ONE)
		else $error("nominal not forced");
	apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready in access cycle");
endmodule // tol_checker
bind tol_trip tol_checker #(.P_CYCLE_CLKS(P_CYCLE_CLKS)) u_tol_checker (.*);
`default_nettype wire

// >>> tb/tol_matrix.sv
`timescale 1ns/1ps
`default_nettype none
module tol_matrix (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// requested level and lag in clocks
	input  wire logic       i_req,
	input  wire logic [3:0] i_lag,
	// block level to the stage
	output logic            o_block
);
	logic [3:0] cnt_q;
	// block lead
	// a slow source lags; the bench raises it long before expiry
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_block <= 1'b0;
			cnt_q   <= 4'h0;
		end else if (i_req == o_block) begin
			cnt_q <= 4'h0;
		end else if (cnt_q >= i_lag) begin
			o_block <= i_req;
			cnt_q   <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // tol_matrix
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int P = 8;
	logic        i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_block, blk_req;
	logic        o_pready, o_pslverr, o_alarm1, o_alarm2, o_inhibit, o_trip, o_start, o_blocked;
	logic        o_blk_evt, o_hmi_evt, perr;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, seed, rdat;
	logic [10:0] i_theta;
	logic [15:0] i_current, o_evt_cur;
	logic [2:0]  o_cond;
	logic [1:0]  o_load, o_evt_type;
	logic [9:0]  o_sf_used, o_k_used, o_inom_used;
	logic [3:0]  o_set_flt, blk_lag;
	logic [10:0] lv [4];
	int          n_mismatch, compares, cyc, k, j, n_evt;
	tol_trip #(.P_CYCLE_CLKS(P)) u_tol_trip (.*);
	tol_matrix u_tol_matrix (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(blk_req), .i_lag(blk_lag),
		.o_block(i_block));
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (o_blk_evt === 1'b1) n_evt <= n_evt + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [1:0] exp_load(input logic [15:0] c);
		if (c < tol_pkg::CUR_1PCT) return tol_pkg::LOAD_LIGHT;
		if (c > tol_pkg::CUR_2IN) return tol_pkg::LOAD_HIGH;
		if (c > tol_pkg::RST_PICKUP) return tol_pkg::LOAD_OVER;
		return tol_pkg::LOAD_NORMAL;
	endfunction
	function automatic logic [2:0] exp_cond(input logic [10:0] t);
		if (t >= lv[3]) return tol_pkg::COND_TRIP;
		if (t >= lv[2]) return tol_pkg::COND_INHIBIT;
		if (t >= lv[1]) return tol_pkg::COND_ALARM2;
		if (t >= lv[0]) return tol_pkg::COND_ALARM1;
		return tol_pkg::COND_NORMAL;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares = compares + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// holds the request until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= w;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		rdat = o_prdata;
		perr = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e, "read");
	endtask
	task automatic tick(input int n);
		repeat (n * P) @(posedge i_core_clk);
	endtask
	task automatic wait_start();
		k = 0;
		while (o_start !== 1'b1 && k < 100) begin
			@(posedge i_core_clk);
			k = k + 1;
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		seed = 32'd20;
		{i_rst_n, i_psel, i_penable, i_pwrite, blk_req} = 5'h0;
		{i_paddr, i_pwdata, i_theta, i_current, blk_lag} = '0;
		{n_mismatch, compares, cyc, n_evt} = '0;
		lv = '{11'h190, 11'h190, 11'h320, 11'h3e8};
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(tol_pkg::A_CTRL, 32'h0);
		for (j = 0; j < 4; j++) rd(8'(4 * j + 4), 32'(lv[j]));
		rd(tol_pkg::A_TRIP_DLY, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk(perr, 1, "unmapped error");
		chk(rdat, 0, "unmapped data");
		i_theta <= 11'h5dc;
		tick(3);
		chk({o_alarm1, o_alarm2, o_inhibit, o_trip, o_start, o_cond}, 0, "disabled");
		apb(1'b1, tol_pkg::A_CTRL, 32'h0f);
		for (k = 0; k < 12; k++) begin
			for (j = 0; j < 4; j++) lv[j] = 11'(rnd() % 1500 + 1);
			for (j = 0; j < 4; j++) apb(1'b1, 8'(4 * j + 4), 32'(lv[j]));
			i_theta <= 11'(lv[rnd() % 4] + 11'(rnd() % 3) - 11'h1);
			tick(2);
			chk({o_alarm1, o_alarm2, o_inhibit, o_trip}, {i_theta >= lv[0], i_theta >= lv[1],
				i_theta >= lv[2], i_theta >= lv[3]}, "levels");
			chk(o_cond, exp_cond(i_theta), "cond");
		end
		apb(1'b1, tol_pkg::A_LVL_TRIP, 32'd1000);
		apb(1'b1, tol_pkg::A_TRIP_DLY, 32'h000fffff);
		rd(tol_pkg::A_TRIP_DLY, 32'(tol_pkg::DLY_MAX));
		apb(1'b1, tol_pkg::A_TRIP_DLY, 32'd3);
		for (j = 0; j < 2; j++) begin
			i_theta <= 11'h0;
			tick(2);
			i_theta <= 11'd1200;
			wait_start();
			if (j == 1) begin
				blk_lag <= 4'h2;
				blk_req <= 1'b1;
				tick(5);
				chk({o_start, o_trip}, 0, "block in start");
				blk_req <= 1'b0;
				wait_start();
			end
			repeat (20) @(posedge i_core_clk);
			chk(o_trip, 0, "delay early");
			repeat (8) @(posedge i_core_clk);
			chk(o_trip, 1, "delay end");
		end
		i_theta <= 11'h0;
		i_current <= 16'h012c;
		blk_req <= 1'b1;
		tick(2);
		j = n_evt;
		i_theta <= 11'd1200;
		tick(2);
		chk({o_blocked, o_start, o_cond}, 5'h15, "blocked");
		chk(n_evt - j, 1, "event count");
		chk({o_evt_cur, o_evt_type}, {i_current, exp_load(i_current)}, "event data");
		blk_req <= 1'b0;
		apb(1'b1, tol_pkg::A_CTRL, 32'h38);
		tick(2);
		chk(o_blocked, 1, "forced block");
		apb(1'b1, tol_pkg::A_CTRL, 32'h28);
		tick(2);
		chk(o_blocked, 0, "switch without forcing");
		for (k = 0; k < 16; k++) begin
			i_current <= (k < 6) ? 16'(k / 2 * 100 + k % 2) : 16'(rnd() % 400);
			repeat (2) @(posedge i_core_clk);
			chk(o_load, exp_load(i_current), "load");
		end
		apb(1'b1, tol_pkg::A_SVC_FAC, 32'd99);
		apb(1'b1, tol_pkg::A_AMB_K, 32'd0);
		apb(1'b1, tol_pkg::A_INOM, 32'd501);
		apb(1'b1, tol_pkg::A_KLIM, 32'h006400c8);
		repeat (2) @(posedge i_core_clk);
		chk(o_set_flt, 4'hf, "fault flags");
		chk(o_sf_used, tol_pkg::K_ONE, "sf forced");
		chk(o_k_used, tol_pkg::K_ONE, "k forced");
		chk(o_inom_used, tol_pkg::K_ONE, "nominal forced");
		apb(1'b1, tol_pkg::A_SVC_FAC, 32'd150);
		apb(1'b1, tol_pkg::A_AMB_K, 32'd250);
		apb(1'b1, tol_pkg::A_INOM, 32'd7);
		apb(1'b1, tol_pkg::A_KLIM, 32'h00c80064);
		repeat (2) @(posedge i_core_clk);
		chk(o_set_flt, 4'h0, "flags clear");
		chk({o_sf_used, o_k_used, o_inom_used}, {10'd150, 10'd250, 10'd7}, "good");
		conclude();
	end
endmodule // testbench
`default_nettype wire
